// ---- rtl/supervisor_pkg.sv ----
// supervisor_pkg: register map, field positions, reset values and timing
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus
package supervisor_pkg;
    // register byte offsets
    localparam logic [7:0] DIAG_OFFSET     = 8'h00;
    localparam logic [7:0] CTRL_OFFSET     = 8'h04;
    localparam logic [7:0] STATE_OFFSET    = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_CLR_OFFSET  = 8'h10;
    localparam logic [7:0] IRQ_EN_OFFSET   = 8'h14;
    localparam logic [7:0] VERSION_OFFSET  = 8'h18;
    // diagnosis fields; interrupt status adds the watchdog bit on top
    localparam int DIAG_RST_BIT  = 0;
    localparam int DIAG_UV_BIT   = 1;
    localparam int DIAG_PUMP_UNDERVOLTAGE_FLAG_BIT = 3;
    localparam int DIAG_CPW_BIT  = 4;
    localparam int DIAG_WIDTH    = 5;
    localparam int IRQ_WD_BIT    = 5;
    localparam int IRQ_WIDTH     = 6;
    localparam int CTRL_CLOCK_WATCHDOG_ENABLE_BIT = 0;
    // live state register fields
    localparam int ST_RESET_BIT  = 0;
    localparam int ST_SLEEP_BIT  = 1;
    localparam int ST_WD_BIT     = 2;
    localparam int ST_STAGE_BIT  = 3;
    // reset values
    localparam logic [DIAG_WIDTH-1:0] DIAG_RESET   = 5'h00;
    localparam logic [IRQ_WIDTH-1:0]  IRQ_RESET    = 6'h00;
    localparam logic                  CLOCK_WATCHDOG_ENABLE_RESET   = 1'b0;
    // timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int POR_PIN_TIME_NS  = 100000;
    localparam int POR_PIN_CYCLES   = POR_PIN_TIME_NS / CLK_PERIOD_NS;
    localparam int POR_UV_CYCLES    = 65536;
    localparam int CNT_W            = 17;
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_SLEEP, ST_HELD, ST_POR, ST_ACTIVE, ST_WDTRIP
    } sup_state_t;
endpackage

// ---- rtl/supply_reset_sleep_supervisor.sv ----
// supply_reset_sleep_supervisor: reset, sleep, watchdog and diagnosis flags
// assumes supply monitor and fault inputs already synchronous to aclk
`timescale 1ns/1ns
module supply_reset_sleep_supervisor
    import supervisor_pkg::*;
#(
    parameter int          POR_UV_LEN = POR_UV_CYCLES,
    parameter logic [31:0] VERSION_ID = 32'h0000_0A51 // arbitrary value
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        logic_supply_ok,
    input  wire logic        analog_supply_ok,
    input  wire logic        reference_supply_ok,
    input  wire logic        interface_supply_ok,
    input  wire logic        reset_input_low,
    input  wire logic        clock_missing,
    input  wire logic [1:0]  load_supply_uv,
    input  wire logic        pump_uv,
    input  wire logic        pump_warn,
    output logic             internal_reset,
    output logic             sleep_mode,
    output logic             watchdog_fault,
    output logic [1:0]       stage_enable,
    output logic             fault_output_low_o,
    output logic             fault_output_low_oe,
    output logic             irq
);
    sup_state_t            state_ff, nxt_state;
    logic [CNT_W-1:0]      cnt_ff, nxt_cnt, por_limit;
    logic                  uv_cause_ff, nxt_uv_cause;
    logic                  clock_watchdog_enable_ff, nxt_clock_watchdog_enable;
    logic [DIAG_WIDTH-1:0] diag_ff, nxt_diag, diag_set;
    logic [IRQ_WIDTH-1:0]  irq_stat_ff, nxt_irq_stat, irq_en_ff, nxt_irq_en;
    logic                  aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
    logic [7:0]            awaddr_ff, nxt_awaddr;
    logic [7:0]            wbyte_ff, nxt_wbyte;
    logic                  wlane_ff, nxt_wlane;
    logic                  bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]            bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0]           rdata_ff, nxt_rdata;
    logic                  supply_bad, active, entering_active, do_write, wr_ok, ar_hs;
    logic                  diag_access, wr_ctrl, wr_clr, wr_en;

    // address decode shared by read and write paths
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            DIAG_OFFSET, CTRL_OFFSET, STATE_OFFSET, IRQ_STAT_OFFSET,
            IRQ_CLR_OFFSET, IRQ_EN_OFFSET, VERSION_OFFSET: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // supply and state decode
    assign supply_bad = !(logic_supply_ok && analog_supply_ok && reference_supply_ok);
    assign active     = (state_ff == ST_ACTIVE);
    assign entering_active = !active && (nxt_state == ST_ACTIVE);
    assign por_limit  = uv_cause_ff ? CNT_W'(POR_UV_LEN - 1) : CNT_W'(POR_PIN_CYCLES - 1);

    // reset sequencer
    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_uv_cause = uv_cause_ff;
        case (state_ff)
            ST_SLEEP: begin
                nxt_uv_cause = 1'b1;
                nxt_state    = ST_POR;
                nxt_cnt      = '0;
            end
            ST_HELD: begin
                // timer begins on the first clock after pin release
                nxt_state = ST_POR;
                nxt_cnt   = '0;
            end
            ST_POR: begin
                // release only once the full interval has run
                if (cnt_ff == por_limit) begin
                    nxt_state    = ST_ACTIVE;
                    nxt_uv_cause = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
            end
            ST_ACTIVE: begin
                if (clock_watchdog_enable_ff && clock_missing) begin
                    nxt_state = ST_WDTRIP;
                end
            end
            ST_WDTRIP: nxt_state = ST_WDTRIP;
            default:   nxt_state = ST_SLEEP;
        endcase
        // supply loss forces sleep, leaves by itself
        if (supply_bad) begin
            nxt_state    = ST_SLEEP;
            nxt_uv_cause = 1'b1;
        end else if (!reset_input_low) begin
            nxt_state = ST_HELD;
            if (state_ff != ST_SLEEP) begin
                nxt_uv_cause = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff    <= ST_SLEEP;
            cnt_ff      <= '0;
            uv_cause_ff <= 1'b1;
        end else if (ce) begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            uv_cause_ff <= nxt_uv_cause;
        end
    end

    // bus handshakes; writes only take effect outside reset
    assign awready  = ce && !aw_have_ff && !bvalid_ff;
    assign wready   = ce && !w_have_ff && !bvalid_ff;
    assign arready  = ce && !rvalid_ff;
    assign ar_hs    = arvalid && arready;
    assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
    // register access refused until the interval is over
    assign wr_ok    = do_write && active && addr_mapped(awaddr_ff);
    assign wr_ctrl  = wr_ok && wlane_ff && (awaddr_ff == CTRL_OFFSET);
    assign wr_clr   = wr_ok && wlane_ff && (awaddr_ff == IRQ_CLR_OFFSET);
    assign wr_en    = wr_ok && wlane_ff && (awaddr_ff == IRQ_EN_OFFSET);
    // write of the diagnosis word, or a read with interface supply present, counts as access
    assign diag_access = (wr_ok && awaddr_ff == DIAG_OFFSET)
                      || (ar_hs && active && interface_supply_ok
                          && araddr == DIAG_OFFSET);

    // write channel
    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_have  = w_have_ff;
        nxt_wbyte   = wbyte_ff;
        nxt_wlane   = wlane_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (awvalid && awready) begin
            nxt_aw_have = 1'b1;
            nxt_awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_have = 1'b1;
            nxt_wbyte  = wdata[7:0];
            nxt_wlane  = wstrb[0];
        end
        if (do_write) begin
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // read channel, answer one cycle after the address is taken
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = '0;
            nxt_rresp  = RESP_OKAY;
            if (state_ff == ST_WDTRIP) begin
                // tripped watchdog answers with the version word
                nxt_rdata = VERSION_ID;
            end else if (!active || !addr_mapped(araddr)) begin
                nxt_rresp = RESP_SLVERR;
            end else if (!interface_supply_ok) begin
                // missing interface supply reads as zero
                nxt_rdata = '0;
            end else begin
                case (araddr)
                    DIAG_OFFSET:     nxt_rdata[DIAG_WIDTH-1:0] = diag_ff;
                    CTRL_OFFSET:     nxt_rdata[CTRL_CLOCK_WATCHDOG_ENABLE_BIT]  = clock_watchdog_enable_ff;
                    STATE_OFFSET: begin
                        nxt_rdata[ST_RESET_BIT] = internal_reset;
                        nxt_rdata[ST_SLEEP_BIT] = sleep_mode;
                        nxt_rdata[ST_WD_BIT]    = watchdog_fault;
                        nxt_rdata[ST_STAGE_BIT+:2] = stage_enable;
                    end
                    IRQ_STAT_OFFSET: nxt_rdata[IRQ_WIDTH-1:0] = irq_stat_ff;
                    IRQ_EN_OFFSET:   nxt_rdata[IRQ_WIDTH-1:0] = irq_en_ff;
                    VERSION_OFFSET:  nxt_rdata = VERSION_ID;
                    default:         nxt_rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            awaddr_ff  <= 8'h00;
            w_have_ff  <= 1'b0;
            wbyte_ff   <= 8'h00;
            wlane_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else if (ce) begin
            aw_have_ff <= nxt_aw_have;
            awaddr_ff  <= nxt_awaddr;
            w_have_ff  <= nxt_w_have;
            wbyte_ff   <= nxt_wbyte;
            wlane_ff   <= nxt_wlane;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    // diagnosis flags, watchdog enable and interrupt registers
    always_comb begin
        diag_set = '0;
        diag_set[DIAG_RST_BIT] = entering_active;
        diag_set[DIAG_UV_BIT+:2]  = active ? load_supply_uv : 2'h0;
        diag_set[DIAG_PUMP_UNDERVOLTAGE_FLAG_BIT]   = active && pump_uv;
        diag_set[DIAG_CPW_BIT]    = active && pump_warn;
        // access clears, but a new event wins
        nxt_diag = (diag_ff & ~{DIAG_WIDTH{diag_access}}) | diag_set;
        if (!active && !entering_active) begin
            nxt_diag = DIAG_RESET;
        end
        nxt_clock_watchdog_enable = wr_ctrl ? wbyte_ff[CTRL_CLOCK_WATCHDOG_ENABLE_BIT] : clock_watchdog_enable_ff;
        if (state_ff == ST_SLEEP || state_ff == ST_HELD) begin
            nxt_clock_watchdog_enable = CLOCK_WATCHDOG_ENABLE_RESET;
        end
        nxt_irq_en   = wr_en ? wbyte_ff[IRQ_WIDTH-1:0] : irq_en_ff;
        nxt_irq_stat = irq_stat_ff & ~(wr_clr ? wbyte_ff[IRQ_WIDTH-1:0] : IRQ_RESET);
        nxt_irq_stat = nxt_irq_stat | {1'b0, diag_set};
        nxt_irq_stat[IRQ_WD_BIT] = nxt_irq_stat[IRQ_WD_BIT]
                                || (active && nxt_state == ST_WDTRIP);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_ff     <= DIAG_RESET;
            clock_watchdog_enable_ff     <= CLOCK_WATCHDOG_ENABLE_RESET;
            irq_en_ff   <= IRQ_RESET;
            irq_stat_ff <= IRQ_RESET;
        end else if (ce) begin
            diag_ff     <= nxt_diag;
            clock_watchdog_enable_ff     <= nxt_clock_watchdog_enable;
            irq_en_ff   <= nxt_irq_en;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // outputs
    assign internal_reset = !active;
    assign sleep_mode     = (state_ff == ST_SLEEP);
    assign watchdog_fault = (state_ff == ST_WDTRIP);
    assign stage_enable   = (active && clock_watchdog_enable_ff && !pump_uv) ? ~load_supply_uv : 2'h0;
    // fault pin pulled low on flagged fault or reset
    assign fault_output_low_o  = 1'b0;
    assign fault_output_low_oe = internal_reset || (|diag_ff[DIAG_WIDTH-1:DIAG_UV_BIT]);
    assign irq    = |(irq_stat_ff & irq_en_ff);
    assign bvalid = bvalid_ff;
    assign bresp  = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata  = rdata_ff;
    assign rresp  = rresp_ff;

    // checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sleep_enter_a: assert property (ce && supply_bad |=> sleep_mode && internal_reset)
        else $error("supply loss did not force sleep");
    wd_trip_a: assert property (ce && active && clock_watchdog_enable_ff && clock_missing && !supply_bad
        && reset_input_low |=> watchdog_fault)
        else $error("watchdog did not trip");
    release_path_a: assert property ($rose(active) |-> $past(state_ff) == ST_POR
        && $past(cnt_ff) == $past(por_limit))
        else $error("reset released early");
    por_start_a: assert property ($rose(state_ff == ST_POR) |-> cnt_ff == '0)
        else $error("timer did not start at zero");
    rst_flag_a: assert property ($rose(active) |-> diag_ff[DIAG_RST_BIT])
        else $error("reset flag not set on exit");
    diag_clear_a: assert property (ce && active && diag_access && !diag_set[DIAG_RST_BIT]
        |=> !diag_ff[DIAG_RST_BIT])
        else $error("diagnosis access did not clear flag");
    load_uv_a: assert property (ce && active && load_supply_uv[0] |-> !stage_enable[0]
        ##1 diag_ff[DIAG_UV_BIT])
        else $error("load undervoltage not handled");
    pump_uv_a: assert property (pump_uv |-> stage_enable == 2'h0)
        else $error("pump undervoltage left a stage on");
    pump_warn_a: assert property (ce && active && pump_warn && !pump_uv && clock_watchdog_enable_ff
        && load_supply_uv == 2'h0 |-> stage_enable == 2'h3 ##1 diag_ff[DIAG_CPW_BIT])
        else $error("pump warning mishandled");
    iface_zero_a: assert property (ar_hs && active && !interface_supply_ok
        |=> rdata == 32'h0000_0000)
        else $error("read data not zero without interface supply");
    wd_version_a: assert property (ar_hs && watchdog_fault |=> rdata == VERSION_ID)
        else $error("tripped read did not return version");
    fault_pin_a: assert property (internal_reset |-> fault_output_low_oe)
        else $error("fault pin released in reset");
    release_c: cover property ($rose(active));
    trip_c: cover property (active ##1 watchdog_fault);
    flag_clear_c: cover property (diag_ff[DIAG_CPW_BIT] ##1 !diag_ff[DIAG_CPW_BIT]);
endmodule

// ---- tb/axi_lite_host.sv ----
// axi_lite_host: register bus master standing in for the microcontroller
// assumes one clock aclk; its tasks are called from the bench top
`timescale 1ns/1ns
module axi_lite_host (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // one write; handshakes seen at the negedge are acted on at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t  = wvalid && wready;
            b_t  = bvalid;
            r    = bresp;
            @(posedge aclk);
            if (aw_t) begin
                awvalid <= 1'b0;
                awaddr  <= ~a; // released lines stop showing the target
            end
            if (w_t) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (b_t) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask
    // one read; data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t  = rvalid;
            d    = rdata;
            r    = rresp;
            @(posedge aclk);
            if (ar_t) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (r_t) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// ---- tb/test_supply_reset_sleep_supervisor.sv ----
// test_supply_reset_sleep_supervisor: bench top for the supply supervisor
// assumes the axi_lite_host model and a shortened undervoltage reset timer
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module test_supply_reset_sleep_supervisor
    import supervisor_pkg::*;
;
    localparam int          POR_LEN = 16;
    localparam logic [31:0] VER     = 32'h0000_5EED; // arbitrary value
    logic        aclk, aresetn, ce, io_ok, clock_missing, pump_uv, pump_warn, reset_input_low;
    logic [2:0]  core_ok;
    logic [1:0]  load_supply_uv, bresp, rresp, stage_enable, r;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        internal_reset, sleep_mode, watchdog_fault, flt_o, flt_oe, irq;
    int          bad_count, compares, n;

    supply_reset_sleep_supervisor #(.POR_UV_LEN(POR_LEN), .VERSION_ID(VER)) dut (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .logic_supply_ok(core_ok[0]), .analog_supply_ok(core_ok[1]),
        .reference_supply_ok(core_ok[2]), .interface_supply_ok(io_ok),
        .reset_input_low, .clock_missing, .load_supply_uv, .pump_uv, .pump_warn,
        .internal_reset, .sleep_mode, .watchdog_fault, .stage_enable,
        .fault_output_low_o(flt_o), .fault_output_low_oe(flt_oe), .irq);
    axi_lite_host host (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    // 10 MHz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // verdict and end of run
    task automatic final_report;
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // settle point for checks: at the k-th falling edge from now
    task automatic step(input int k);
        repeat (k) @(negedge aclk);
    endtask
    // count cycles until internal reset releases, bounded
    task automatic wait_active;
        n = 0;
        while (internal_reset !== 1'b0 && n < 3000) begin
            @(negedge aclk);
            n++;
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        host.rd(a, d, r);
        `CHK(d, ed)
        `CHK(r, er)
    endtask
    task automatic chk_wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
        host.wr(a, dv, r);
        `CHK(r, er)
    endtask
    // first power-up: sleep, timer, reset flag set then cleared by access
    task automatic t_power_on;
        @(negedge aclk);
        `CHK({sleep_mode, internal_reset, flt_oe}, 3'b111)
        `CHK(flt_o, 1'b0)
        wait_active;
        `CHK(n >= POR_LEN - 1 && n <= POR_LEN + 3, 1'b1)
        chk_rd(DIAG_OFFSET, 32'h1, RESP_OKAY);
        chk_rd(DIAG_OFFSET, 32'h0, RESP_OKAY);
        `CHK(flt_oe, 1'b0)
    endtask
    // watchdog off ignores the clock; stage faults and recovery
    task automatic t_stages;
        @(posedge aclk);
        clock_missing <= 1'b1;
        step(3);
        `CHK({internal_reset, stage_enable}, 3'b000)
        @(posedge aclk);
        clock_missing <= 1'b0;
        chk_wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
        step(1);
        `CHK(stage_enable, 2'b11)
        @(posedge aclk);
        load_supply_uv <= 2'b01;
        step(2);
        `CHK({stage_enable, flt_oe}, 3'b101)
        @(posedge aclk);
        load_supply_uv <= 2'b00;
        pump_warn      <= 1'b1;
        step(2);
        `CHK({stage_enable, flt_oe}, 3'b111)
        @(posedge aclk);
        pump_warn <= 1'b0;
        pump_uv   <= 1'b1;
        step(2);
        `CHK(stage_enable, 2'b00)
        @(posedge aclk);
        pump_uv <= 1'b0;
        chk_rd(DIAG_OFFSET, 32'h1A, RESP_OKAY);
        chk_rd(DIAG_OFFSET, 32'h0, RESP_OKAY);
        `CHK({stage_enable, flt_oe}, 3'b110)
    endtask
    // interrupt raise, clear, mask; unmapped address refused
    task automatic t_irq;
        chk_wr(IRQ_CLR_OFFSET, 32'h3F, RESP_OKAY);
        chk_wr(IRQ_EN_OFFSET, 32'h2, RESP_OKAY);
        step(1);
        `CHK(irq, 1'b0)
        @(posedge aclk);
        load_supply_uv <= 2'b01;
        step(2);
        `CHK(irq, 1'b1)
        @(posedge aclk);
        load_supply_uv <= 2'b10;
        chk_wr(IRQ_CLR_OFFSET, 32'h2, RESP_OKAY);
        @(posedge aclk);
        load_supply_uv <= 2'b00;
        step(1);
        `CHK({irq, stage_enable}, 3'b011)
        chk_rd(IRQ_STAT_OFFSET, 32'h4, RESP_OKAY);
        chk_wr(IRQ_EN_OFFSET, 32'h4, RESP_OKAY);
        step(1);
        `CHK(irq, 1'b1)
        chk_wr(IRQ_CLR_OFFSET, 32'h4, RESP_OKAY);
        step(1);
        `CHK(irq, 1'b0)
        chk_wr(8'h1C, 32'h1, RESP_SLVERR);
        chk_rd(8'h1C, 32'h0, RESP_SLVERR);
        chk_rd(DIAG_OFFSET, 32'h6, RESP_OKAY);
    endtask
    // interface supply absent: reads answer zero
    task automatic t_iface;
        @(posedge aclk);
        io_ok <= 1'b0;
        chk_rd(STATE_OFFSET, 32'h0, RESP_OKAY);
        @(posedge aclk);
        io_ok <= 1'b1;
        chk_rd(STATE_OFFSET, 32'h18, RESP_OKAY);
        // frozen block does not flag a load fault and refuses the bus
        @(posedge aclk);
        ce             <= 1'b0;
        load_supply_uv <= 2'b01;
        step(2);
        `CHK({awready, wready, arready, flt_oe}, 4'b0000)
        @(posedge aclk);
        ce             <= 1'b1;
        load_supply_uv <= 2'b00;
        step(1);
        `CHK(flt_oe, 1'b0)
    endtask
    // watchdog trip, version answers, exit by the reset pin
    task automatic t_watchdog;
        @(posedge aclk);
        clock_missing <= 1'b1;
        step(3);
        `CHK({watchdog_fault, internal_reset, stage_enable, flt_oe}, 5'b11001)
        chk_rd(DIAG_OFFSET, VER, RESP_OKAY);
        chk_rd(8'h1C, VER, RESP_OKAY);
        @(posedge aclk);
        clock_missing   <= 1'b0;
        reset_input_low <= 1'b0;
        step(3);
        `CHK({watchdog_fault, sleep_mode, internal_reset, flt_oe}, 4'b0011)
        @(posedge aclk);
        reset_input_low <= 1'b1;
        chk_rd(DIAG_OFFSET, 32'h0, RESP_SLVERR);
        wait_active;
        `CHK(n >= POR_PIN_CYCLES - 10 && n <= POR_PIN_CYCLES, 1'b1)
        chk_rd(DIAG_OFFSET, 32'h1, RESP_OKAY);
    endtask
    // each core supply in turn forces sleep and leaves it alone
    task automatic t_sleep;
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            core_ok[i] <= 1'b0;
            step(3);
            `CHK({sleep_mode, internal_reset, flt_oe, stage_enable}, 5'b11100)
            @(posedge aclk);
            core_ok[i] <= 1'b1;
            wait_active;
            `CHK(n >= POR_LEN - 1 && n <= POR_LEN + 3, 1'b1)
            chk_rd(DIAG_OFFSET, 32'h1, RESP_OKAY);
        end
        // a write to the diagnosis word clears a pending fault flag
        @(posedge aclk);
        load_supply_uv <= 2'b10;
        @(posedge aclk);
        load_supply_uv <= 2'b00;
        step(1);
        `CHK(flt_oe, 1'b1)
        chk_wr(DIAG_OFFSET, 32'h0, RESP_OKAY);
        chk_rd(DIAG_OFFSET, 32'h0, RESP_OKAY);
    endtask
    // main sequence
    initial begin
        bad_count       = 0;
        compares        = 0;
        n               = 0;
        aresetn         = 1'b0;
        ce              = 1'b1;
        io_ok           = 1'b1;
        clock_missing   = 1'b0;
        pump_uv         = 1'b0;
        pump_warn       = 1'b0;
        reset_input_low = 1'b1;
        core_ok         = 3'b111;
        load_supply_uv  = 2'b00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_power_on;
        t_stages;
        t_irq;
        t_iface;
        t_watchdog;
        t_sleep;
        final_report;
    end
    // hang guard, about four times the expected run
    initial begin
        #500000;
        bad_count++;
        final_report;
    end
endmodule
